// *** inc/cmps_pkg.sv ***
// Constants and carrier types shared by the current-mode PWM supervisor.
package cmps_pkg;
  // ----------------------------------------------------------------
  // Clock and timing figures
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned T_STARTUP_MS = 15;
  localparam int unsigned T_SS_MS      = 10;
  localparam int unsigned T_OVL_MS     = 22;
  localparam int unsigned STARTUP_CYC  = T_STARTUP_MS * (CLK_HZ / 1000);
  localparam int unsigned SS_CYC       = T_SS_MS * (CLK_HZ / 1000);
  localparam int unsigned OVL_CYC      = T_OVL_MS * (CLK_HZ / 1000);
  // ----------------------------------------------------------------
  // Oscillator and dither
  // ----------------------------------------------------------------
  localparam int unsigned F_MIN_HZ     = 63_000;
  localparam int unsigned F_STEP_HZ    = 250;
  localparam int unsigned F_NOM_HZ     = 65_000;
  localparam int unsigned F_SWEEP_HZ   = 125;
  localparam int unsigned DITHER_STEPS = 16;
  localparam int unsigned STEP_CYC     = CLK_HZ / (F_SWEEP_HZ * DITHER_STEPS);
  localparam int unsigned MAX_DUTY_PCT = 75;
  // ----------------------------------------------------------------
  // Analogue levels as 12-bit codes (burst levels 13-bit), 1 mV per LSB
  // ----------------------------------------------------------------
  localparam logic [11:0] MV_SS_BEGIN  = 12'h1f4;
  localparam logic [11:0] MV_SS_END    = 12'h3e8;
  localparam logic [11:0] MV_CHG_OFF   = 12'h5dc;
  localparam logic [11:0] MV_PULSE_END = 12'h3e8;
  localparam logic [12:0] MV_BURST_ON  = 13'h03b6;
  localparam logic [12:0] MV_BURST_OFF = 13'h0370;
  localparam logic [11:0] MV_OVL_REF   = 12'h032;
  localparam logic [11:0] GAIN_NUM     = 12'h28f;
  localparam int unsigned GAIN_SHIFT   = 12;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_SSLEVEL = 8'h08;
  localparam logic [7:0]  REG_PERIOD  = 8'h0c;
  localparam int unsigned CTRL_DITHER = 0;
  localparam int unsigned CTRL_GATE   = 1;
  localparam logic [1:0]  CTRL_RESET  = 2'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic vccStart;
    logic vccStop;
    logic vccReset;
    logic vccOver;
    logic latchTrip;
    logic lineLow;
    logic lineRecovered;
  } cmps_flags_s;
  typedef enum logic [1:0] {ST_UVLO, ST_SOFT, ST_RUN} cmps_state_e;
endpackage : cmps_pkg

// *** rtl/cmps_osc.sv ***
// Dithered switching oscillator of the current-mode PWM supervisor.
`timescale 1ns/10ps
module cmps_osc
  import cmps_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Control
  input  wire logic       runEn,
  input  wire logic       ditherEn,
  // Timing
  output logic            cycleStart,
  output logic            onWindow,
  output logic [7:0]      period
);
  logic [15:0] stepCnt_q;
  logic [3:0]  stepIdx_q;
  logic [7:0]  cnt_q;
  logic [7:0]  period_q;

  function automatic logic [7:0] periodOf(input logic [3:0] idx, input logic dith);
    int unsigned f;
    f = dith ? F_MIN_HZ + F_STEP_HZ * idx : F_NOM_HZ;
    periodOf = 8'(CLK_HZ / f);
  endfunction : periodOf

  // The sweep runs freely so that a restart does not reset the dither phase.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stepCnt_q <= 16'h0000;
      stepIdx_q <= 4'h0;
    end else if (stepCnt_q == 16'(STEP_CYCLES - 1)) begin
      stepCnt_q <= 16'h0000;
      stepIdx_q <= stepIdx_q + 4'h1;
    end else begin
      stepCnt_q <= stepCnt_q + 16'h0001;
    end
  end

  // A new period is taken only at a cycle boundary to avoid runt pulses.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q    <= 8'h00;
      period_q <= 8'(CLK_HZ / F_NOM_HZ);
    end else if (!runEn || cnt_q == period_q - 8'h01) begin
      cnt_q    <= 8'h00;
      period_q <= periodOf(stepIdx_q, ditherEn);
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign cycleStart = runEn && cnt_q == 8'h00;
  assign onWindow   = runEn && (16'(cnt_q) * 16'd100 < 16'(period_q) * 16'(MAX_DUTY_PCT));
  assign period     = period_q;

  chk_step_pacing: assert property (@(posedge clk_sys) disable iff (!resetn)
    $changed(stepIdx_q) |-> stepCnt_q == 16'h0000)
    else $error("dither step changed off its pacing boundary");
  chk_period_range: assert property (@(posedge clk_sys) disable iff (!resetn)
    period_q >= 8'(CLK_HZ / 67_000) && period_q <= 8'(CLK_HZ / F_MIN_HZ))
    else $error("switching period outside the dither band");
endmodule : cmps_osc

// *** rtl/cmps_top.sv ***
// Start-up, soft-start, pulse-end and protection logic of the PWM supervisor.
`timescale 1ns/10ps
// Overview of operation
// - Charging path off 15 ms after start.
// - Soft start from start threshold to 1 V.
// - At 8 V: charge, stop drive, zero ramp.
// - Restart and rerun soft start after lockout.
// - Soft-start ramp 0.5 to 1 V over 10 ms.
// - Charging path off when ramp hits 1.5 V.
// - Dither between 63 and 67 kHz, 16 steps.
// - 250 Hz steps; sweep repeats at 125 Hz.
// - Gate off when sense meets 1 V minus offset.
// - No internal blanking on sense input.
// - Burst above 0.95 V, leave below 0.88 V.
// - Burst comparison sampled only with gate off.
// - Clock phase high: sense below 50 mV runs timer.
// - Overload 22 ms trips; cleared only by lockout.
// - Sense overload detection only after soft start.
// - Line flag below 2 V, 0.5 V hysteresis.
// - Line flag stops gate; 22 ms trips overload.
// - Latch input above 4 V latches until 5 V.
// - Supply at 19 V latches until 5 V.
module cmps_top
  import cmps_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYC,
  parameter int unsigned SS_CYCLES      = SS_CYC,
  parameter int unsigned OVL_CYCLES     = OVL_CYC,
  parameter int unsigned STEP_CYCLES    = STEP_CYC
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // Analogue front end
  input  wire cmps_flags_s       cmpFlagsRaw,
  input  wire logic [11:0]       senseCode,
  input  wire logic [11:0]       latchPinCode,
  // Power stage
  output logic                   gateOut,
  output logic                   chargeEn,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  // AXI4-Lite write data and response
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);
  localparam int unsigned SS_STEP = SS_CYCLES / 500;

  cmps_flags_s syncA_q, syncB_q, syncC_q, flags_q;
  cmps_state_e state_q;
  logic [11:0] ssLevel_q;
  logic [15:0] ssTick_q;
  logic [19:0] startCnt_q;
  logic [19:0] ovlCnt_q;
  logic [11:0] offset_q;
  logic        chargeEn_q, gate_q, burst_q, ovlShut_q, supOver_q, latchShut_q;
  logic        lineUv_q, senseLow_q;
  logic [1:0]  ctrl_q;
  logic        cycleStart, onWindow, startNow, ovlRun, shutdown;
  logic [7:0]  period;
  logic [11:0] pulseThr;
  logic [12:0] burstSum;

  // ----------------------------------------------------------------
  // Comparator flag synchronisers
  // ----------------------------------------------------------------
  // A flag moves only once two later stages agree, so a crossing that
  // chatters for one clock is never acted upon.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      syncA_q <= '0;
      syncB_q <= '0;
      syncC_q <= '0;
      flags_q <= '0;
    end else begin
      syncA_q <= cmpFlagsRaw;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      if (syncB_q == syncC_q) begin
        flags_q <= syncC_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-limit offset and comparison levels
  // ----------------------------------------------------------------
  function automatic logic [11:0] gainOf(input logic [11:0] lvl);
    logic [23:0] prod;
    prod   = lvl * GAIN_NUM;
    gainOf = prod[GAIN_SHIFT+11:GAIN_SHIFT];
  endfunction : gainOf

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      offset_q <= 12'h000;
    end else begin
      offset_q <= gainOf(latchPinCode);
    end
  end

  // While soft start runs the ramp replaces the normal threshold.
  assign pulseThr = (state_q == ST_SOFT) ? ssLevel_q : MV_PULSE_END - offset_q;
  assign burstSum = {1'b0, senseCode} + {1'b0, offset_q};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign startNow = flags_q.vccStart && !flags_q.vccStop && !latchShut_q && !supOver_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_UVLO;
    end else if (flags_q.vccStop) begin
      state_q <= ST_UVLO;
    end else begin
      case (state_q)
        ST_UVLO: begin
          if (startNow) begin
            state_q <= ST_SOFT;
          end
        end
        ST_SOFT: begin
          if (ssLevel_q >= MV_SS_END) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_UVLO;
        end
      endcase
    end
  end

  // The ramp keeps rising after soft start so the 1.5 V charge cut-off works.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ssLevel_q <= 12'h000;
      ssTick_q  <= 16'h0000;
    end else if (state_q == ST_UVLO || flags_q.vccStop) begin
      ssLevel_q <= startNow && state_q == ST_UVLO ? MV_SS_BEGIN : 12'h000;
      ssTick_q  <= 16'h0000;
    end else if (ssTick_q == 16'(SS_STEP - 1)) begin
      ssTick_q <= 16'h0000;
      if (ssLevel_q < MV_CHG_OFF) begin
        ssLevel_q <= ssLevel_q + 12'h001;
      end
    end else begin
      ssTick_q <= ssTick_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Start-up charging path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      startCnt_q <= 20'h00000;
      chargeEn_q <= 1'b1;
    end else if (state_q == ST_UVLO) begin
      startCnt_q <= 20'h00000;
      chargeEn_q <= 1'b1;
    end else begin
      if (startCnt_q != 20'(STARTUP_CYCLES - 1)) begin
        startCnt_q <= startCnt_q + 20'h00001;
      end
      if (startCnt_q == 20'(STARTUP_CYCLES - 1) || ssLevel_q >= MV_CHG_OFF) begin
        chargeEn_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Protections
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latchShut_q <= 1'b0;
      supOver_q   <= 1'b0;
    end else begin
      if (flags_q.latchTrip) begin
        latchShut_q <= 1'b1;
      end else if (flags_q.vccReset) begin
        latchShut_q <= 1'b0;
      end
      if (flags_q.vccOver) begin
        supOver_q <= 1'b1;
      end else if (flags_q.vccReset) begin
        supOver_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lineUv_q <= 1'b0;
    end else if (flags_q.lineLow) begin
      lineUv_q <= 1'b1;
    end else if (flags_q.lineRecovered) begin
      lineUv_q <= 1'b0;
    end
  end

  // The off part of the switching cycle is the internal clock's high phase.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      senseLow_q <= 1'b0;
    end else if (state_q != ST_UVLO && !onWindow) begin
      senseLow_q <= senseCode < MV_OVL_REF;
    end
  end

  assign ovlRun = (state_q == ST_RUN && senseLow_q)
               || (state_q != ST_UVLO && lineUv_q);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ovlCnt_q  <= 20'h00000;
      ovlShut_q <= 1'b0;
    end else if (state_q == ST_UVLO) begin
      ovlCnt_q  <= 20'h00000;
      ovlShut_q <= 1'b0;
    end else if (!ovlRun) begin
      ovlCnt_q <= 20'h00000;
    end else if (ovlCnt_q == 20'(OVL_CYCLES - 1)) begin
      ovlShut_q <= 1'b1;
    end else begin
      ovlCnt_q <= ovlCnt_q + 20'h00001;
    end
  end

  // ----------------------------------------------------------------
  // Burst mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      burst_q <= 1'b0;
    end else if (state_q == ST_UVLO) begin
      burst_q <= 1'b0;
    end else if (!gate_q) begin
      if (burstSum > MV_BURST_ON) begin
        burst_q <= 1'b1;
      end else if (burstSum < MV_BURST_OFF) begin
        burst_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator and gate
  // ----------------------------------------------------------------
  cmps_osc #(
    .STEP_CYCLES (STEP_CYCLES)
  ) uOsc (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .runEn      (state_q != ST_UVLO),
    .ditherEn   (ctrl_q[CTRL_DITHER]),
    .cycleStart (cycleStart),
    .onWindow   (onWindow),
    .period     (period)
  );

  assign shutdown = state_q == ST_UVLO || ovlShut_q || supOver_q || latchShut_q
                 || lineUv_q || burst_q || !ctrl_q[CTRL_GATE];

  // Sense is compared raw every clock; turn-on noise must be filtered outside.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gate_q <= 1'b0;
    end else if (shutdown) begin
      gate_q <= 1'b0;
    end else if (cycleStart) begin
      gate_q <= senseCode < pulseThr;
    end else if (!onWindow || senseCode >= pulseThr) begin
      gate_q <= 1'b0;
    end
  end

  assign gateOut  = gate_q;
  assign chargeEn = chargeEn_q;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic              awHeld_q, wHeld_q, bvalid_q, rvalid_q, doWrite;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0]       wData_q, rdata_q, readMux;
  logic [3:0]        wStrb_q;
  logic [1:0]        bresp_q, rresp_q, readResp;

  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready  = !wHeld_q;
  assign s_axi_arready = !rvalid_q;
  assign doWrite       = awHeld_q && wHeld_q && !bvalid_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= '0;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !awHeld_q) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_q) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      ctrl_q   <= CTRL_RESET;
    end else if (doWrite) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (awAddr_q > REG_PERIOD || awAddr_q[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      if (awAddr_q == REG_CTRL && wStrb_q[0]) begin
        ctrl_q <= wData_q[1:0];
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_comb begin
    readMux  = 32'h00000000;
    readResp = RESP_OKAY;
    case (s_axi_araddr)
      REG_CTRL:    readMux = {30'h0, ctrl_q};
      REG_STATUS:  readMux = {23'h0, gate_q, chargeEn_q, lineUv_q, latchShut_q,
                              supOver_q, ovlShut_q, burst_q, state_q};
      REG_SSLEVEL: readMux = {20'h0, ssLevel_q};
      REG_PERIOD:  readMux = {24'h0, period};
      default:     readResp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= readMux;
      rresp_q  <= readResp;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seqRestart;
    state_q == ST_UVLO ##1 state_q == ST_SOFT;
  endsequence

  chk_soft_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
    seqRestart |-> ssLevel_q == MV_SS_BEGIN && gate_q == 1'b0)
    else $error("soft start did not restart from the ramp floor");
  chk_gate_forced: assert property (@(posedge clk_sys) disable iff (!resetn)
    shutdown |=> !gate_q)
    else $error("gate stayed on during a shutdown condition");
  chk_pulse_end: assert property (@(posedge clk_sys) disable iff (!resetn)
    gate_q && senseCode >= pulseThr && !cycleStart |=> !gate_q)
    else $error("gate not ended at the pulse-end threshold");
  chk_uvlo_entry: assert property (@(posedge clk_sys) disable iff (!resetn)
    flags_q.vccStop |=> state_q == ST_UVLO && ssLevel_q == 12'h000 ##1 chargeEn_q)
    else $error("lockout did not recharge or collapse the ramp");
  chk_supply_over: assert property (@(posedge clk_sys) disable iff (!resetn)
    flags_q.vccOver |=> supOver_q [*2] or !flags_q.vccOver)
    else $error("supply over-voltage shutdown not latched");
  chk_latch_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    latchShut_q && !flags_q.vccReset |=> latchShut_q)
    else $error("latch shutdown released above the reset level");
  chk_ovl_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
    ovlShut_q && state_q != ST_UVLO |=> ovlShut_q)
    else $error("overload shutdown cleared without lockout");
  chk_ovl_gated: assert property (@(posedge clk_sys) disable iff (!resetn)
    state_q == ST_SOFT && !lineUv_q |=> ovlCnt_q == 20'h00000)
    else $error("overload timer ran before soft start finished");
  chk_burst_sample: assert property (@(posedge clk_sys) disable iff (!resetn)
    $changed(burst_q) && state_q != ST_UVLO |-> !$past(gate_q))
    else $error("burst state moved while the gate was on");
  chk_charge_cut: assert property (@(posedge clk_sys) disable iff (!resetn)
    state_q != ST_UVLO && startCnt_q == 20'(STARTUP_CYCLES - 1) |=> !chargeEn_q)
    else $error("charging path left on after the start-up interval");
endmodule : cmps_top

// *** sim/cmps_front_model.sv ***
// Comparators and current-sense ramp facing the PWM supervisor.
`timescale 1ns/10ps
module cmps_front_model
  import cmps_pkg::*;
(
  // Clock and gate
  input  wire logic  clk_sys,
  input  wire logic  gateOut,
  // Analogue levels in mV
  input  wire logic [31:0] vccMv,
  input  wire logic [31:0] lineMv,
  input  wire logic [31:0] latchMv,
  input  wire logic [31:0] fbMv,
  // Front-end outputs
  output cmps_flags_s cmpFlagsRaw,
  output logic [11:0] senseCode,
  output logic [11:0] latchPinCode
);
  logic [11:0] ramp_q = 12'h000;
  // Switch current rises 10 mV a clock while the gate is on.
  always_ff @(posedge clk_sys) ramp_q <= gateOut ? ramp_q + 12'h00a : 12'h000;
  // Switch current stops the moment the gate drops, so the off-time sense is feedback only.
  assign senseCode = fbMv[11:0] + (gateOut ? ramp_q : 12'h000);
  assign latchPinCode = (latchMv > 4095) ? 12'hfff : latchMv[11:0];
  always_comb begin
    cmpFlagsRaw.vccStart = vccMv >= 12000;
    cmpFlagsRaw.vccStop = vccMv < 8000;
    cmpFlagsRaw.vccReset = vccMv < 5000;
    cmpFlagsRaw.vccOver = vccMv >= 19000;
    cmpFlagsRaw.latchTrip = latchMv > 4000;
    cmpFlagsRaw.lineLow = lineMv < 2000;
    cmpFlagsRaw.lineRecovered = lineMv > 2500;
  end
endmodule : cmps_front_model

// *** sim/testbench.sv ***
// Self-checking bench of the PWM supervisor over AXI4-Lite.
`timescale 1ns/10ps
module testbench
  import cmps_pkg::*;
;
  logic clk_sys = 1'b0, resetn = 1'b0, gateOut, chargeEn, seenG = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv, pMin, pMax;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [11:0] senseCode, latchPinCode;
  cmps_flags_s cmpFlagsRaw;
  int vccMv = 0, lineMv = 3000, latchMv = 0, fbMv = 300, bad_count = 0, n_tests = 0;
  cmps_top #(.STARTUP_CYCLES(1500), .SS_CYCLES(5000), .OVL_CYCLES(2000),
    .STEP_CYCLES(200)) uut (.*);
  cmps_front_model front (.*);
  initial forever #50 clk_sys = ~clk_sys;
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd
  task automatic waitbit(int b, logic v, string nm);
    for (int i = 0; i < 2500; i++) begin
      rd(REG_STATUS);
      if (rdv[b] === v) break;
    end
    chk(nm, rdv[b], v);
  endtask : waitbit
  task automatic stbit(int b, logic v, string nm);
    repeat (100) @(posedge clk_sys);
    rd(REG_STATUS);
    chk(nm, rdv[b], v);
  endtask : stbit
  task automatic report_and_stop;
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // Long enough for two soft starts, two overload trips and one sweep.
  initial begin
    #(60000 * 100);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(REG_CTRL);
    chk("ctrl", rdv, {30'h0, CTRL_RESET});
    vccMv <= 14000;
    waitbit(0, 1'b1, "soft");
    rd(REG_SSLEVEL);
    chk("ss start", rdv >= 500 && rdv <= 505, 1'b1);
    repeat (1400) @(posedge clk_sys);
    chk("charge on", chargeEn, 1'b1);
    repeat (200) @(posedge clk_sys);
    chk("charge off", chargeEn, 1'b0);
    waitbit(1, 1'b1, "run");
    rd(REG_SSLEVEL);
    chk("ss end", rdv >= 1000, 1'b1);
    wr(REG_CTRL, 32'h2);
    repeat (400) @(posedge clk_sys);
    rd(REG_PERIOD);
    chk("period", rdv, CLK_HZ / F_NOM_HZ);
    wr(REG_CTRL, 32'h1);
    stbit(8, 1'b0, "gate disabled");
    rd(REG_CTRL);
    chk("ctrl wr", rdv, 32'h1);
    wr(REG_CTRL, 32'h3);
    pMin = 32'hffff;
    pMax = 32'h0;
    repeat (1300) begin
      rd(REG_PERIOD);
      seenG |= gateOut;
      if (rdv < pMin) pMin = rdv;
      if (rdv > pMax) pMax = rdv;
    end
    chk("p max", pMax, CLK_HZ / F_MIN_HZ);
    chk("p min", pMin, CLK_HZ / (F_MIN_HZ + 15 * F_STEP_HZ));
    chk("gate", seenG, 1'b1);
    latchMv <= 1000;
    fbMv <= 800;
    waitbit(2, 1'b1, "burst in");
    chk("burst gate", gateOut, 1'b0);
    fbMv <= 750;
    stbit(2, 1'b1, "burst hold");
    fbMv <= 700;
    waitbit(2, 1'b0, "burst out");
    latchMv <= 0;
    fbMv <= 300;
    lineMv <= 1500;
    waitbit(6, 1'b1, "line low");
    chk("line gate", gateOut, 1'b0);
    lineMv <= 2200;
    stbit(6, 1'b1, "line hyst");
    lineMv <= 1500;
    waitbit(3, 1'b1, "line ovl");
    lineMv <= 3000;
    stbit(3, 1'b1, "ovl held");
    vccMv <= 7000;
    waitbit(1, 1'b0, "lockout");
    chk("uvlo charge", chargeEn, 1'b1);
    vccMv <= 14000;
    waitbit(0, 1'b1, "restart");
    chk("ovl clear", rdv[3], 1'b0);
    fbMv <= 0;
    stbit(3, 1'b0, "no ovl soft");
    waitbit(3, 1'b1, "ovl");
    chk("ovl gate", gateOut, 1'b0);
    latchMv <= 4500;
    waitbit(5, 1'b1, "latch");
    latchMv <= 0;
    vccMv <= 7000;
    stbit(5, 1'b1, "latch held");
    vccMv <= 4000;
    waitbit(5, 1'b0, "latch clr");
    vccMv <= 20000;
    waitbit(4, 1'b1, "ovp");
    chk("ovp gate", gateOut, 1'b0);
    vccMv <= 14000;
    stbit(4, 1'b1, "ovp held");
    vccMv <= 4000;
    waitbit(4, 1'b0, "ovp clr");
    rd(8'h10);
    chk("rd unmapped", {rdv[29:0], resp}, {30'h0, RESP_SLVERR});
    wr(8'h10, 32'h0);
    chk("wr unmapped", resp, RESP_SLVERR);
    report_and_stop();
  end
endmodule : testbench
